/* File: riu_rotate_unit.sv */
// rotate instruction datapath: memory byte in, memory or working register out
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module riu_rotate_unit #(
    parameter int DATA_W = riu_pkg::DATA_W,
    parameter int ADDR_W = riu_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic op_valid_i,
    input wire logic [2:0] op_sel_i,
    input wire logic [ADDR_W-1:0] op_addr_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire logic carry_i,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    output logic mem_we_o,
    output logic [DATA_W-1:0] working_register_o,
    output logic working_we_o,
    output logic carry_o,
    output logic carry_we_o,
    output logic done_o
);
    if (DATA_W != riu_pkg::DATA_W || ADDR_W < 1) begin : g_param_check
        $error("riu_rotate_unit: DATA_W must be 8 and ADDR_W positive");
    end

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        riu_pkg::riu_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic mem_we;
        logic [DATA_W-1:0] working;
        logic working_we;
        logic carry;
        logic carry_we;
        logic done;
    } riu_state_t;

    riu_state_t st;
    riu_state_t next_st;

    logic rot_left;
    logic rot_carry;
    logic to_mem;
    logic flag_upd;
    riu_pkg::riu_op_t dec_op;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry_out;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    always_comb begin
        rot_left = 1'b0;
        rot_carry = 1'b0;
        to_mem = 1'b0;
        flag_upd = 1'b0;
        dec_op = riu_pkg::RIU_OP_NONE;
        case (op_sel_i)
            riu_pkg::SEL_LEFT_CARRY_MEM: begin
                rot_left = 1'b1;
                rot_carry = 1'b1;
                to_mem = 1'b1;
                flag_upd = 1'b1;
                dec_op = riu_pkg::RIU_OP_LEFT_CARRY_MEM;
            end
            riu_pkg::SEL_LEFT_CARRY_WORK: begin
                rot_left = 1'b1;
                rot_carry = 1'b1;
                flag_upd = 1'b1;
                dec_op = riu_pkg::RIU_OP_LEFT_CARRY_WORK;
            end
            riu_pkg::SEL_RIGHT_MEM: begin
                to_mem = 1'b1;
                dec_op = riu_pkg::RIU_OP_RIGHT_MEM;
            end
            riu_pkg::SEL_RIGHT_WORK: begin
                dec_op = riu_pkg::RIU_OP_RIGHT_WORK;
            end
            riu_pkg::SEL_RIGHT_CARRY_MEM: begin
                rot_carry = 1'b1;
                to_mem = 1'b1;
                flag_upd = 1'b1;
                dec_op = riu_pkg::RIU_OP_RIGHT_CARRY_MEM;
            end
            riu_pkg::SEL_RIGHT_CARRY_WORK: begin
                rot_carry = 1'b1;
                flag_upd = 1'b1;
                dec_op = riu_pkg::RIU_OP_RIGHT_CARRY_WORK;
            end
            riu_pkg::SEL_LEFT_WORK: begin
                rot_left = 1'b1;
                dec_op = riu_pkg::RIU_OP_NONE;
            end
            default: begin
                dec_op = riu_pkg::RIU_OP_NONE;
            end
        endcase
    end

    riu_rotator #(
        .WIDTH(DATA_W)
    ) u_rot (
        .data_i(mem_rdata_i),
        .carry_i(carry_i),
        .left_i(rot_left),
        .through_carry_i(rot_carry),
        .result_o(rot_result),
        .carry_o(rot_carry_out)
    );

    // ------------------------------------------------------------------------
    // next state: one-cycle commit
    // ------------------------------------------------------------------------
    logic sel_ok;
    assign sel_ok = op_sel_i != riu_pkg::SEL_NONE;

    always_comb begin
        next_st = st;
        next_st.mem_we = 1'b0;
        next_st.working_we = 1'b0;
        next_st.carry_we = 1'b0;
        next_st.done = 1'b0;
        next_st.op = riu_pkg::RIU_OP_NONE;
        if (op_valid_i && sel_ok) begin
            next_st.op = dec_op;
            next_st.addr = op_addr_i;
            next_st.done = 1'b1;
            if (to_mem) begin
                next_st.wdata = rot_result;
                next_st.mem_we = 1'b1;
            end else begin
                next_st.working = rot_result;
                next_st.working_we = 1'b1;
            end
            if (flag_upd) begin
                next_st.carry = rot_carry_out;
                next_st.carry_we = 1'b1;
            end
        end
    end

    // reset acts only while enabled: a low enable freezes everything
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (!rst_n_i) begin
                st.op <= riu_pkg::RIU_OP_NONE;
                st.addr <= '0;
                st.wdata <= '0;
                st.mem_we <= 1'b0;
                st.working <= riu_pkg::WORKING_RESET;
                st.working_we <= 1'b0;
                st.carry <= riu_pkg::CARRY_RESET;
                st.carry_we <= 1'b0;
                st.done <= 1'b0;
            end else begin
                st <= next_st;
            end
        end
    end

    assign mem_addr_o = st.addr;
    assign mem_wdata_o = st.wdata;
    assign mem_we_o = st.mem_we;
    assign working_register_o = st.working;
    assign working_we_o = st.working_we;
    assign carry_o = st.carry;
    assign carry_we_o = st.carry_we;
    assign done_o = st.done;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    // issue as the unit samples it, reset included
    sequence s_issue(logic [2:0] s);
        rst_n_i && ce_i && op_valid_i && op_sel_i == s;
    endsequence

    // done follows the previous edge: reset, fresh issue or frozen
    sequence s_next_done;
        done_o == $past(ce_i ? (rst_n_i && op_valid_i && op_sel_i != riu_pkg::SEL_NONE)
            : done_o);
    endsequence

    left_carry_mem_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_LEFT_CARRY_MEM) |=>
        mem_we_o && carry_we_o && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(carry_i)}
        && carry_o == $past(mem_rdata_i[7]) && mem_addr_o == $past(op_addr_i))
        else $error("left rotate through carry to memory wrong");

    left_carry_work_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_LEFT_CARRY_WORK) |=>
        !mem_we_o && working_we_o && carry_we_o && carry_o == $past(mem_rdata_i[7])
        && working_register_o == {$past(mem_rdata_i[6:0]), $past(carry_i)})
        else $error("left rotate through carry to working wrong");

    right_mem_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_RIGHT_MEM) |=>
        mem_we_o && !carry_we_o && mem_wdata_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])})
        else $error("right rotate to memory wrong");

    right_work_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_RIGHT_WORK) |=> !mem_we_o && !carry_we_o && working_we_o
        && working_register_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])})
        else $error("right rotate to working wrong");

    right_carry_mem_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_RIGHT_CARRY_MEM) |=> mem_we_o && carry_we_o
        && carry_o == $past(mem_rdata_i[0])
        && mem_wdata_o == {$past(carry_i), $past(mem_rdata_i[7:1])})
        else $error("right rotate through carry to memory wrong");

    right_carry_work_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_RIGHT_CARRY_WORK) |=> !mem_we_o && carry_we_o
        && carry_o == $past(mem_rdata_i[0])
        && working_register_o == {$past(carry_i), $past(mem_rdata_i[7:1])})
        else $error("right rotate through carry to working wrong");

    left_work_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_issue(riu_pkg::SEL_LEFT_WORK) |=> !mem_we_o && !carry_we_o && working_we_o
        && working_register_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])})
        else $error("left rotate to working wrong");

    one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i && ce_i && op_valid_i && op_sel_i != riu_pkg::SEL_NONE
        |=> done_o ##1 s_next_done)
        else $error("rotate not committed in one cycle");

    frozen_hold_a: assert property (@(posedge clk_i)
        !ce_i |=> $stable({mem_addr_o, mem_wdata_o, mem_we_o, working_register_o,
        working_we_o, carry_o, carry_we_o, done_o}))
        else $error("outputs moved while clock enable low");
endmodule : riu_rotate_unit
`default_nettype wire

/* File: riu_pkg.sv */
// shared constants and types for the rotate instruction unit
package riu_pkg;
    localparam int DATA_W = 8;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int ADDR_W = 8;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    // one-hot operation codes
    typedef enum logic [6:0] {
        RIU_OP_NONE = 7'h01,
        RIU_OP_LEFT_CARRY_MEM = 7'h02,
        RIU_OP_LEFT_CARRY_WORK = 7'h04,
        RIU_OP_RIGHT_MEM = 7'h08,
        RIU_OP_RIGHT_WORK = 7'h10,
        RIU_OP_RIGHT_CARRY_MEM = 7'h20,
        RIU_OP_RIGHT_CARRY_WORK = 7'h40
    } riu_op_t;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_LEFT_CARRY_MEM = 3'h1;
    localparam logic [2:0] SEL_LEFT_CARRY_WORK = 3'h2;
    localparam logic [2:0] SEL_RIGHT_MEM = 3'h3;
    localparam logic [2:0] SEL_RIGHT_WORK = 3'h4;
    localparam logic [2:0] SEL_RIGHT_CARRY_MEM = 3'h5;
    localparam logic [2:0] SEL_RIGHT_CARRY_WORK = 3'h6;
    localparam logic [2:0] SEL_LEFT_WORK = 3'h7;
endpackage : riu_pkg

/* File: riu_rotator.sv */
// combinational one-bit rotator with optional carry
`timescale 1ns/1ns
`default_nettype none
module riu_rotator #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] data_i,
    input wire logic carry_i,
    input wire logic left_i,
    input wire logic through_carry_i,
    output logic [WIDTH-1:0] result_o,
    output logic carry_o
);
    if (WIDTH < 2) begin : g_width_check
        $error("riu_rotator: WIDTH must be at least 2");
    end

    logic fill_left;
    logic fill_right;
    assign fill_left = through_carry_i ? carry_i : data_i[WIDTH-1];
    assign fill_right = through_carry_i ? carry_i : data_i[0];

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            if (g == 0) begin : g_lo
                assign result_o[g] = left_i ? fill_left : data_i[g+1];
            end else if (g == WIDTH - 1) begin : g_hi
                assign result_o[g] = left_i ? data_i[g-1] : fill_right;
            end else begin : g_mid
                assign result_o[g] = left_i ? data_i[g-1] : data_i[g+1];
            end
        end
    endgenerate

    assign carry_o = left_i ? data_i[WIDTH-1] : data_i[0];
endmodule : riu_rotator
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the rotate instruction unit
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic op_valid_i = 1'b0;
    logic [2:0] op_sel_i = 3'h0;
    logic [7:0] op_addr_i = 8'h00;
    logic [7:0] mem_rdata_i = 8'h00;
    logic carry_i = 1'b0;
    logic [7:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic mem_we_o;
    logic [7:0] working_register_o;
    logic working_we_o;
    logic carry_o;
    logic carry_we_o;
    logic done_o;
    integer seed = 32'h0bdd;
    int bad_count = 0;
    int comparisons = 0;
    bit armed = 1'b0;
    logic [3:0] e_pulse = 4'h0;
    logic [7:0] e_work = 8'h00;
    logic [7:0] e_addr = 8'h00;
    logic [7:0] e_wdata = 8'h00;
    logic e_carry = 1'b0;
    logic m_mem = 1'b0;
    logic m_carry = 1'b0;
    logic [2:0] p_sel = 3'h0;
    logic [28:0] seen;
    logic [28:0] want;
    logic [11:0] r;

    always #2 clk_i = ~clk_i;

    riu_rotate_unit riu_rotate_unit_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
        .op_sel_i(op_sel_i), .op_addr_i(op_addr_i), .mem_rdata_i(mem_rdata_i),
        .carry_i(carry_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o), .working_register_o(working_register_o),
        .working_we_o(working_we_o), .carry_o(carry_o), .carry_we_o(carry_we_o),
        .done_o(done_o)
    );

    // ------------------------------------------------------------
    // reference: {mem_we, working_we, carry_we, new carry, result}
    // ------------------------------------------------------------
    function automatic logic [11:0] rot_model(input logic [2:0] s, input logic [7:0] d,
                                              input logic c);
        case (s)
            3'h1: return {3'b101, d[7], d[6:0], c};
            3'h2: return {3'b011, d[7], d[6:0], c};
            3'h3: return {3'b100, c, d[0], d[7:1]};
            3'h4: return {3'b010, c, d[0], d[7:1]};
            3'h5: return {3'b101, d[0], c, d[7:1]};
            3'h6: return {3'b011, d[0], c, d[7:1]};
            3'h7: return {3'b010, c, d[6:0], d[7]};
            default: return 12'h000;
        endcase
    endfunction : rot_model

    task automatic check(input logic [28:0] got, input logic [28:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // compare last cycle's prediction, then advance with inputs for the next edge
    always @(negedge clk_i) begin
        seen = {mem_we_o, working_we_o, carry_we_o, done_o, working_register_o,
                m_mem ? {mem_addr_o, mem_wdata_o} : 16'h0000, m_carry ? carry_o : 1'b0};
        want = {e_pulse, e_work, m_mem ? {e_addr, e_wdata} : 16'h0000,
                m_carry ? e_carry : 1'b0};
        if (armed) begin
            case (p_sel)
                3'h1: check(seen, want, "left via carry to memory");
                3'h2: check(seen, want, "left via carry to working");
                3'h3: check(seen, want, "right to memory");
                3'h4: check(seen, want, "right to working");
                3'h5: check(seen, want, "right via carry to memory");
                3'h6: check(seen, want, "right via carry to working");
                3'h7: check(seen, want, "left to working");
                default: check(seen, want, "idle or reset outputs");
            endcase
        end
        armed = 1'b1;
        if (ce_i) begin
            r = rot_model(op_sel_i, mem_rdata_i, carry_i);
            if (!rst_n_i) begin
                {e_pulse, e_work, e_addr, e_wdata, e_carry} = 29'h0;
                {m_mem, m_carry, p_sel} = 5'b11000;
            end else if (op_valid_i && op_sel_i != 3'h0) begin
                e_pulse = {r[11:9], 1'b1};
                {m_mem, m_carry, p_sel} = {r[11], r[9], op_sel_i};
                if (r[11])
                    {e_addr, e_wdata} = {op_addr_i, r[7:0]};
                if (r[10])
                    e_work = r[7:0];
                if (r[9])
                    e_carry = r[8];
            end else begin
                {e_pulse, m_mem, m_carry, p_sel} = 9'h000;
            end
        end
    end

    task automatic drive(input logic rst, input logic e, input logic v, input logic [2:0] s,
                         input logic [7:0] a, input logic [7:0] d, input logic c);
        @(posedge clk_i);
        {rst_n_i, ce_i, op_valid_i} <= {rst, e, v};
        {op_sel_i, op_addr_i, mem_rdata_i, carry_i} <= {s, a, d, c};
    endtask : drive

    task automatic random_run(input int n);
        logic [31:0] x;
        for (int i = 0; i < n; i++) begin
            x = $random(seed);
            drive(1'b1, |x[7:5], x[0] | x[1], x[4:2], x[15:8], x[23:16], x[24]);
        end
    endtask : random_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        // issue right at release, then every code back to back on edge patterns
        for (int k = 0; k < 4; k++) begin
            for (int s = 1; s < 8; s++) begin
                drive(1'b1, 1'b1, 1'b1, s[2:0], 8'(s * 17 + k), k[1] ? 8'h7e : 8'h81, k[0]);
            end
        end
        // stall with a pulse pending, then a refused issue
        drive(1'b1, 1'b0, 1'b1, 3'h5, 8'h3c, 8'h01, 1'b1);
        drive(1'b1, 1'b1, 1'b1, 3'h1, 8'h3d, 8'h80, 1'b0);
        drive(1'b1, 1'b0, 1'b1, 3'h2, 8'h3e, 8'hff, 1'b1);
        drive(1'b1, 1'b0, 1'b0, 3'h6, 8'h3f, 8'h55, 1'b1);
        drive(1'b1, 1'b1, 1'b1, 3'h0, 8'h40, 8'haa, 1'b1);
        drive(1'b1, 1'b1, 1'b0, 3'h3, 8'h41, 8'haa, 1'b1);
        random_run(600);
        // reset while frozen is ignored, then reset in mid-run with an issue pending
        drive(1'b0, 1'b0, 1'b1, 3'h2, 8'h42, 8'hc3, 1'b1);
        drive(1'b0, 1'b1, 1'b1, 3'h2, 8'h42, 8'hc3, 1'b1);
        random_run(300);
        drive(1'b1, 1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
        repeat (2) @(posedge clk_i);
        end_sim();
    end

    initial begin
        #40000;
        bad_count++;
        $display("[FAIL] %0t run did not finish", $time);
        end_sim();
    end
endmodule : tb
`default_nettype wire
